// [rtl/dlc_regs.sv]
// Delay-lock, bias and decoder configuration registers with the loop controller.
// Assumes a byte register port from the serial configuration engine, and a
// phase detector giving one measurement per phase_valid pulse.
//
// Behaviour
// - Delay is nine bits: LSB at bit 7 of low register, rest in high register.
// - The lock search begins at the programmed delay value.
// - In manual mode, delay writes set the delay line value.
// - In tracking mode, reading the delay returns the sampled value.
// - Direction code: 00 down, 01 up, 10 both ways, 11 invalid.
// - Target phase above 16 never locks; software keeps it at most 16.
// - In search, at the target phase, measurement slope is compared with the set polarity.
// - Bias register bit 7 set powers the converter down.
// - Roll-off code: 00 bypass, 01 narrow, 10 medium, 11 widest.
// - Decoder code: 00 normal, 01 return-to-zero, 10 mix, 11 invalid.
// - Mode code: 00 search then track, 01 track, 10 search, 11 invalid.
// - Capture bit rising latches locked delay and phase for readback.
// - Loop enable 0 is manual mode, 1 is automatic operation.
// - Slope bit 0 demands negative slope, 1 positive slope.
`timescale 1ns/100ps
`include "dlc_cfg.svh"

module dlc_regs
  import dlc_pkg::*;
#(
  parameter int DW = 9,
  parameter int PW = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata_ff,
  input  wire logic          phase_valid,
  input  wire logic [PW-1:0] phase_meas,
  output logic      [DW-1:0] delay_tap_value,
  output logic               loop_locked,
  output logic               converter_power_down,
  output logic      [1:0]    mirror_rolloff_select,
  output logic      [1:0]    decoder_mode
);

  logic [7:0]    ctrl_ff;
  logic [7:0]    bias_ff;
  logic [7:0]    dec_ff;
  logic [7:0]    dlylo_ff;
  logic [7:0]    dlyhi_ff;
  logic          capt_prev_ff;
  logic [DW-1:0] samp_delay_ff;
  logic [PW-1:0] samp_phase_ff;
  logic [7:0]    nxt_rdata;
  logic          loop_en;
  logic          capt_rise;
  logic [DW-1:0] prog_delay;
  logic [DW-1:0] lock_delay;
  logic [PW-1:0] lock_phase;
  logic [1:0]    mode;
  logic [1:0]    dir;
  logic [PW-1:0] target_phase_code;

  // ****************************************
  // Field decode
  // ****************************************
  assign loop_en           = ctrl_ff[`DLC_CTRL_EN];
  assign mode              = ctrl_ff[`DLC_CTRL_MODE_LO +: 2];
  assign dir               = dlylo_ff[`DLC_DIR_LO +: 2];
  assign target_phase_code = dlylo_ff[PW-1:0];
  assign prog_delay        = {dlyhi_ff, dlylo_ff[`DLC_DLY_LSB]};
  assign capt_rise         = ctrl_ff[`DLC_CTRL_CAPT] & ~capt_prev_ff;

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `DLC_RST_CTRL;
    end else if (reg_wr_en && reg_addr == `DLC_ADDR_CTRL) begin
      ctrl_ff <= reg_wdata;
    end
  end

  // ****************************************
  // Bias and decoder registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bias_ff <= `DLC_RST_BIAS;
    end else if (reg_wr_en && reg_addr == `DLC_ADDR_BIAS) begin
      bias_ff <= reg_wdata & `DLC_MASK_BIAS;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_ff <= `DLC_RST_DEC;
    end else if (reg_wr_en && reg_addr == `DLC_ADDR_DEC) begin
      dec_ff <= reg_wdata & `DLC_MASK_DEC;
    end
  end

  assign converter_power_down  = bias_ff[`DLC_BIAS_PD];
  assign mirror_rolloff_select = bias_ff[1:0];
  assign decoder_mode          = dec_ff[1:0];

  // ****************************************
  // Delay, direction and target phase
  // ****************************************
  // The delay bits only take writes in manual mode; the loop owns them otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dlylo_ff <= `DLC_RST_DLYLO;
    end else if (reg_wr_en && reg_addr == `DLC_ADDR_DLYLO) begin
      dlylo_ff[6:0] <= reg_wdata[6:0];
      if (!loop_en) begin
        dlylo_ff[`DLC_DLY_LSB] <= reg_wdata[`DLC_DLY_LSB];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dlyhi_ff <= `DLC_RST_DLYHI;
    end else if (reg_wr_en && reg_addr == `DLC_ADDR_DLYHI && !loop_en) begin
      dlyhi_ff <= reg_wdata;
    end
  end

  // ****************************************
  // Lock result capture
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capt_prev_ff  <= 1'b0;
      samp_delay_ff <= '0;
      samp_phase_ff <= '0;
    end else begin
      capt_prev_ff <= ctrl_ff[`DLC_CTRL_CAPT];
      if (capt_rise) begin
        samp_delay_ff <= lock_delay;
        samp_phase_ff <= lock_phase;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped offsets and reserved bias and decoder bits read as zero; control bits 7, 2 and 1 read as written
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `DLC_ADDR_CTRL:  nxt_rdata = ctrl_ff;
      `DLC_ADDR_BIAS:  nxt_rdata = bias_ff;
      `DLC_ADDR_DEC:   nxt_rdata = dec_ff;
      `DLC_ADDR_DLYLO: begin
        if (loop_en) begin
          nxt_rdata = {samp_delay_ff[0], dir, samp_phase_ff};
        end else begin
          nxt_rdata = dlylo_ff;
        end
      end
      `DLC_ADDR_DLYHI: begin
        nxt_rdata = loop_en ? samp_delay_ff[DW-1:1] : dlyhi_ff;
      end
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Loop controller
  // ****************************************
  dlc_loop #(
    .DW (DW),
    .PW (PW)
  ) u_loop (
    .clk           (clk),
    .rst_b         (rst_b),
    .loop_en       (loop_en),
    .mode          (mode),
    .dir           (dir),
    .slope_pos     (ctrl_ff[`DLC_CTRL_SLOPE]),
    .target        (target_phase_code),
    .start_delay   (prog_delay),
    .manual_delay  (prog_delay),
    .phase_valid   (phase_valid),
    .phase_meas    (phase_meas),
    .delay_out_ff  (lock_delay),
    .locked_ff     (loop_locked),
    .lock_phase_ff (lock_phase)
  );

  // Tracking delay is what drives the delay line; read only through a capture
  assign delay_tap_value = lock_delay;

  // ****************************************
  // Checks
  // ****************************************
  chk_delay_write_block: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_DLYHI && loop_en) |=> $stable(dlyhi_ff))
    else $error("delay written while loop enabled");

  chk_manual_delay: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_DLYHI && !loop_en) ##1 !loop_en
      |=> delay_tap_value[DW-1:1] == $past(reg_wdata, 2))
    else $error("manual high delay bits not applied");

  chk_track_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr == `DLC_ADDR_DLYHI && loop_en) |=>
      reg_rdata_ff == $past(samp_delay_ff[DW-1:1]))
    else $error("tracking read did not return the sampled delay");

  chk_capture_edge: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(ctrl_ff[`DLC_CTRL_CAPT]) |=>
      samp_delay_ff == $past(lock_delay) && samp_phase_ff == $past(lock_phase))
    else $error("capture edge did not latch lock result");

  chk_capture_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl_ff[`DLC_CTRL_CAPT] && capt_prev_ff) |=> $stable(samp_delay_ff))
    else $error("readback changed without a capture edge");

  chk_power_down: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_BIAS) |=>
      converter_power_down == $past(reg_wdata[`DLC_BIAS_PD]) &&
      mirror_rolloff_select == $past(reg_wdata[1:0]))
    else $error("bias write not reflected at outputs");

  chk_decoder_mode: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_DEC) |=> decoder_mode == $past(reg_wdata[1:0]))
    else $error("decoder mode write not reflected");

  chk_mode_track: assert property (@(posedge clk) disable iff (!rst_b)
    (!loop_en ##1 (loop_en && mode == `DLC_MODE_TRACK) [*2]) |->
      u_loop.state_ff == DLC_ST_TRACK)
    else $error("track-only mode did not enter tracking");

  chk_track_up: assert property (@(posedge clk) disable iff (!rst_b)
    (loop_en && u_loop.state_ff == DLC_ST_TRACK && phase_valid && ctrl_ff[`DLC_CTRL_SLOPE]
     && target_phase_code <= `DLC_PHASE_MAX && phase_meas < target_phase_code
     && delay_tap_value != `DLC_DELAY_MAX) |=> delay_tap_value == $past(delay_tap_value) + DW'(1))
    else $error("tracking did not step the delay up");

  chk_lo_write_block: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_DLYLO && loop_en) |=> $stable(dlylo_ff[`DLC_DLY_LSB]))
    else $error("delay low bit written while loop enabled");

  chk_hi_write: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_DLYHI && !loop_en) |=> dlyhi_ff == $past(reg_wdata))
    else $error("manual high delay write not stored");

  chk_dir_write: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_DLYLO) |=>
      dir == $past(reg_wdata[`DLC_DIR_LO +: 2]) && target_phase_code == $past(reg_wdata[PW-1:0]))
    else $error("direction or target phase write not stored");

  chk_manual_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr == `DLC_ADDR_DLYLO && !loop_en) |=> reg_rdata_ff == $past(dlylo_ff))
    else $error("manual read did not return the written low register");

  chk_track_read_lo: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr == `DLC_ADDR_DLYLO && loop_en) |=>
      reg_rdata_ff == {$past(samp_delay_ff[0]), $past(dir), $past(samp_phase_ff)})
    else $error("tracking low read did not return the sampled values");

  chk_manual_unlocked: assert property (@(posedge clk) disable iff (!rst_b)
    !loop_en |=> !loop_locked)
    else $error("lock reported in manual mode");

  chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr == `DLC_ADDR_CTRL) |=> loop_en == $past(reg_wdata[`DLC_CTRL_EN]))
    else $error("loop enable write not stored");

  // Reads outside the map must not leak stale data from an earlier access
  chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd_en && !(reg_addr inside {`DLC_ADDR_CTRL, `DLC_ADDR_BIAS, `DLC_ADDR_DEC,
                                      `DLC_ADDR_DLYLO, `DLC_ADDR_DLYHI})) |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read did not return zero");

  chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd_en |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");

  cov_lock_search: cover property (@(posedge clk) disable iff (!rst_b)
    loop_en && mode == `DLC_MODE_ST ##[1:1000] $rose(loop_locked));

  cov_both_dir: cover property (@(posedge clk) disable iff (!rst_b)
    loop_en && dir == `DLC_DIR_BOTH ##[1:1000] $rose(loop_locked));

  cov_capture: cover property (@(posedge clk) disable iff (!rst_b)
    loop_locked ##1 capt_rise);

  cov_track_only: cover property (@(posedge clk) disable iff (!rst_b)
    loop_en && mode == `DLC_MODE_TRACK ##[1:20] phase_valid);

  cov_power_down: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(converter_power_down));

endmodule : dlc_regs

// [rtl/dlc_cfg.svh]
// Offsets, field positions, codes and reset values of the delay-lock register bank.
// Assumes byte-wide registers behind the serial configuration port.
`ifndef DLC_CFG_SVH
`define DLC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define DLC_ADDR_CTRL     8'h33
`define DLC_ADDR_BIAS     8'h36
`define DLC_ADDR_DEC      8'h38
`define DLC_ADDR_DLYLO    8'h39
`define DLC_ADDR_DLYHI    8'h3A

// ****************************************
// Field positions
// ****************************************
`define DLC_CTRL_SLOPE    6
`define DLC_CTRL_MODE_LO  4
`define DLC_CTRL_CAPT     3
`define DLC_CTRL_EN       0
`define DLC_BIAS_PD       7
`define DLC_DLY_LSB       7
`define DLC_DIR_LO        5

// ****************************************
// Field codes and limits
// ****************************************
`define DLC_DIR_DOWN      2'h0
`define DLC_DIR_UP        2'h1
`define DLC_DIR_BOTH      2'h2
`define DLC_MODE_ST       2'h0
`define DLC_MODE_TRACK    2'h1
`define DLC_MODE_SEARCH   2'h2
`define DLC_PHASE_MAX     5'h10
`define DLC_DELAY_MAX     9'h1AF

// ****************************************
// Reset values and writable masks
// ****************************************
`define DLC_RST_CTRL      8'h40
`define DLC_RST_BIAS      8'h00
`define DLC_RST_DEC       8'h00
`define DLC_RST_DLYLO     8'h4E
`define DLC_RST_DLYHI     8'h6C
`define DLC_MASK_BIAS     8'h83
`define DLC_MASK_DEC      8'h03

`endif

// [rtl/dlc_pkg.sv]
// Types shared by the delay-lock register bank and its loop controller.
// Assumes nothing beyond a SystemVerilog compiler.
package dlc_pkg;

  // ****************************************
  // Loop controller states
  // ****************************************
  typedef enum logic [1:0] {
    DLC_ST_IDLE,
    DLC_ST_SEARCH,
    DLC_ST_TRACK,
    DLC_ST_HOLD
  } dlc_state_type;

endpackage : dlc_pkg

// [rtl/dlc_loop.sv]
// Delay-lock loop controller: search from a start delay, then track the target phase.
// Assumes one phase measurement per phase_valid pulse, synchronous to clk.
`timescale 1ns/100ps
`include "dlc_cfg.svh"

module dlc_loop
  import dlc_pkg::*;
#(
  parameter int DW = 9,
  parameter int PW = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          loop_en,
  input  wire logic [1:0]    mode,
  input  wire logic [1:0]    dir,
  input  wire logic          slope_pos,
  input  wire logic [PW-1:0] target,
  input  wire logic [DW-1:0] start_delay,
  input  wire logic [DW-1:0] manual_delay,
  input  wire logic          phase_valid,
  input  wire logic [PW-1:0] phase_meas,
  output logic      [DW-1:0] delay_out_ff,
  output logic               locked_ff,
  output logic      [PW-1:0] lock_phase_ff
);

  dlc_state_type state_ff;
  logic [PW-1:0] prev_phase_ff;
  logic          have_prev_ff;
  logic          up_ff;
  logic          target_ok;
  logic          slope_ok;
  logic          hit;
  logic          trk_up;

  // ****************************************
  // Point acceptance
  // ****************************************
  // A target above the limit is never accepted, so the loop cannot lock
  assign target_ok = (target <= `DLC_PHASE_MAX);
  assign slope_ok  = have_prev_ff && ((phase_meas > prev_phase_ff) == slope_pos);
  assign hit       = target_ok && slope_ok && (phase_meas == target);
  assign trk_up    = ((phase_meas < target) == slope_pos);

  // ****************************************
  // Search and track sequencing
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff      <= DLC_ST_IDLE;
      delay_out_ff  <= '0;
      locked_ff     <= 1'b0;
      lock_phase_ff <= '0;
      prev_phase_ff <= '0;
      have_prev_ff  <= 1'b0;
      up_ff         <= 1'b0;
    end else if (!loop_en) begin
      state_ff     <= DLC_ST_IDLE;
      delay_out_ff <= manual_delay;
      locked_ff    <= 1'b0;
      have_prev_ff <= 1'b0;
    end else begin
      case (state_ff)
        DLC_ST_IDLE: begin
          delay_out_ff <= start_delay;
          up_ff        <= (dir != `DLC_DIR_DOWN);
          have_prev_ff <= 1'b0;
          // An invalid mode code, or an invalid direction code outside track mode, leaves the loop parked
          if (mode == `DLC_MODE_TRACK) begin
            state_ff <= DLC_ST_TRACK;
          end else if (mode != 2'h3 && dir != 2'h3) begin
            state_ff <= DLC_ST_SEARCH;
          end
        end
        DLC_ST_SEARCH: begin
          if (phase_valid) begin
            prev_phase_ff <= phase_meas;
            have_prev_ff  <= 1'b1;
            if (hit) begin
              locked_ff     <= 1'b1;
              lock_phase_ff <= phase_meas;
              state_ff <= (mode == `DLC_MODE_SEARCH) ? DLC_ST_HOLD : DLC_ST_TRACK;
            end else if (up_ff && delay_out_ff == `DLC_DELAY_MAX) begin
              // End of the line: both-way search turns round at the start point
              up_ff        <= (dir != `DLC_DIR_BOTH);
              delay_out_ff <= start_delay;
              have_prev_ff <= 1'b0;
            end else if (!up_ff && delay_out_ff == '0) begin
              up_ff        <= (dir == `DLC_DIR_BOTH);
              delay_out_ff <= start_delay;
              have_prev_ff <= 1'b0;
            end else if (up_ff) begin
              delay_out_ff <= delay_out_ff + DW'(1);
            end else begin
              delay_out_ff <= delay_out_ff - DW'(1);
            end
          end
        end
        DLC_ST_TRACK: begin
          if (phase_valid) begin
            lock_phase_ff <= phase_meas;
            locked_ff     <= target_ok && (phase_meas == target);
            if (target_ok && phase_meas != target) begin
              if (trk_up && delay_out_ff != `DLC_DELAY_MAX) begin
                delay_out_ff <= delay_out_ff + DW'(1);
              end else if (!trk_up && delay_out_ff != '0) begin
                delay_out_ff <= delay_out_ff - DW'(1);
              end
            end
          end
        end
        DLC_ST_HOLD: begin
          state_ff <= DLC_ST_HOLD;
        end
        default: begin
          state_ff <= DLC_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_no_big_lock: assert property (@(posedge clk) disable iff (!rst_b)
    (target > `DLC_PHASE_MAX) [*2] |-> !locked_ff)
    else $error("lock reported with target phase above limit");

  chk_search_start: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_ff == DLC_ST_SEARCH) |-> delay_out_ff == $past(start_delay))
    else $error("search did not begin at the start delay");

  chk_down_step: assert property (@(posedge clk) disable iff (!rst_b)
    (loop_en && state_ff == DLC_ST_SEARCH && phase_valid && !hit && !up_ff
     && delay_out_ff != '0) |=> delay_out_ff == $past(delay_out_ff) - DW'(1))
    else $error("downward search did not step down by one");

  chk_slope_lock: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(locked_ff) && $past(state_ff) == DLC_ST_SEARCH) |->
      $past(have_prev_ff) && (($past(phase_meas) > $past(prev_phase_ff)) == $past(slope_pos)))
    else $error("lock accepted with wrong slope");

  chk_manual_follow: assert property (@(posedge clk) disable iff (!rst_b)
    !loop_en |=> delay_out_ff == $past(manual_delay))
    else $error("manual delay not applied to the delay line");

endmodule : dlc_loop

// [sim/dlc_regs_bench.sv]
// Self-checking bench for the delay-lock, bias and decoder register bank.
// Assumes dlc_regs with its byte register port; the bench drives all inputs.
`timescale 1ns/100ps
`include "dlc_cfg.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module dlc_regs_bench;
  import dlc_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic       clk;
  logic       rst_b;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_ff;
  logic       phase_valid;
  logic [4:0] phase_meas;
  logic [8:0] delay_tap_value;
  logic       loop_locked;
  logic       converter_power_down;
  logic [1:0] mirror_rolloff_select;
  logic [1:0] decoder_mode;
  int         errors;
  int         checks;
  logic [7:0] t_ctrl [6] = '{8'h41, 8'h41, 8'h41, 8'h11, 8'h61, 8'h51};
  logic [7:0] t_lo   [6] = '{8'h0E, 8'h2E, 8'h4E, 8'h2E, 8'h2E, 8'h2E};
  logic [8:0] t_dly  [6] = '{9'h0D7, 9'h0D9, 9'h0D9, 9'h0D7, 9'h0D9, 9'h0D9};

  dlc_regs dlc_regs_i (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .reg_wr_en             (reg_wr_en),
    .reg_rd_en             (reg_rd_en),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata_ff          (reg_rdata_ff),
    .phase_valid           (phase_valid),
    .phase_meas            (phase_meas),
    .delay_tap_value       (delay_tap_value),
    .loop_locked           (loop_locked),
    .converter_power_down  (converter_power_down),
    .mirror_rolloff_select (mirror_rolloff_select),
    .decoder_mode          (decoder_mode)
  );

  // ****************************************
  // Clock and port tasks
  // ****************************************
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    @(negedge clk);
  endtask : wr

  // Read data is registered, so it is looked at one edge after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk);
    reg_rd_en = 1'b0;
    `CHK(reg_rdata_ff, exp)
    @(negedge clk);
  endtask : rd

  task automatic meas(input logic [4:0] p);
    phase_valid = 1'b1;
    phase_meas  = p;
    @(negedge clk);
    phase_valid = 1'b0;
    @(negedge clk);
  endtask : meas

  // Loop is turned off first so the start delay and low register take the writes
  task automatic cfg_search(input logic [7:0] ctrl, input logic [7:0] lo);
    wr(`DLC_ADDR_CTRL, 8'h40);
    wr(`DLC_ADDR_DLYLO, lo);
    wr(`DLC_ADDR_DLYHI, 8'h6C);
    wr(`DLC_ADDR_CTRL, ctrl);
    repeat (3) @(negedge clk);
  endtask : cfg_search

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    errors      = 0;
    checks      = 0;
    rst_b       = 1'b0;
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    phase_valid = 1'b0;
    phase_meas  = 5'h00;
    repeat (3) @(negedge clk);
    `CHK(delay_tap_value, 9'h000)
    `CHK(converter_power_down, 1'b0)
    rst_b = 1'b1;
    @(negedge clk);
    rd(`DLC_ADDR_CTRL, `DLC_RST_CTRL);
    rd(`DLC_ADDR_BIAS, `DLC_RST_BIAS);
    rd(`DLC_ADDR_DEC, `DLC_RST_DEC);
    rd(`DLC_ADDR_DLYLO, `DLC_RST_DLYLO);
    rd(`DLC_ADDR_DLYHI, `DLC_RST_DLYHI);
    `CHK(delay_tap_value, 9'h0D8)
    wr(8'h37, 8'hFF);
    rd(8'h37, 8'h00);
    // Bias: every roll-off code, power-down toggled, reserved bits read 0
    for (int i = 0; i < 4; i++) begin
      wr(`DLC_ADDR_BIAS, 8'h7C | 8'(i) | {i[0], 7'h00});
      `CHK(mirror_rolloff_select, i[1:0])
      `CHK(converter_power_down, i[0])
      rd(`DLC_ADDR_BIAS, 8'(i) | {i[0], 7'h00});
    end
    for (int i = 0; i < 3; i++) begin
      wr(`DLC_ADDR_DEC, 8'hFC | 8'(i));
      `CHK(decoder_mode, i[1:0])
      rd(`DLC_ADDR_DEC, 8'(i));
    end
    // Manual mode: largest legal delay split across both registers
    wr(`DLC_ADDR_CTRL, 8'h40);
    wr(`DLC_ADDR_DLYHI, 8'hD7);
    wr(`DLC_ADDR_DLYLO, 8'hCE);
    `CHK(delay_tap_value, `DLC_DELAY_MAX)
    `CHK(loop_locked, 1'b0)
    rd(`DLC_ADDR_DLYLO, 8'hCE);
    // Direction and mode codes: first step away from start 216
    for (int i = 0; i < 6; i++) begin
      cfg_search(t_ctrl[i], t_lo[i]);
      `CHK(delay_tap_value, 9'h0D8)
      meas(5'd10);
      `CHK(delay_tap_value, t_dly[i])
    end
    // Lock on rising phase at target 14, then capture the result
    cfg_search(8'h41, 8'h2E);
    meas(5'd10);
    meas(5'd12);
    `CHK(loop_locked, 1'b0)
    meas(5'd14);
    `CHK(loop_locked, 1'b1)
    `CHK(delay_tap_value, 9'h0DA)
    wr(`DLC_ADDR_CTRL, 8'h49);
    @(negedge clk);
    rd(`DLC_ADDR_DLYLO, 8'h2E);
    rd(`DLC_ADDR_DLYHI, 8'h6D);
    wr(`DLC_ADDR_DLYHI, 8'h00);
    rd(`DLC_ADDR_DLYHI, 8'h6D);
    // Negative slope demanded: the same rising sequence must not lock
    cfg_search(8'h01, 8'h2E);
    meas(5'd10);
    meas(5'd12);
    meas(5'd14);
    `CHK(loop_locked, 1'b0)
    // Target above 16 never locks
    cfg_search(8'h41, 8'h31);
    meas(5'd15);
    meas(5'd17);
    `CHK(loop_locked, 1'b0)
    end_of_test();
  end

endmodule : dlc_regs_bench
